/* File: include/sbc_map.vh */
// Register map, reset values, limits and encodings of the servo control bank
`ifndef SBC_MAP_VH
`define SBC_MAP_VH

// Register indices; byte address is four times the index
`define SBC_IDX_CTRL_MODE 12'h200
`define SBC_IDX_ABS_SYS 12'h201
`define SBC_IDX_ROT_DIR 12'h202
`define SBC_IDX_PULSE_PH 12'h203
`define SBC_IDX_ENOFF_STOP 12'h205
`define SBC_IDX_FLT2_STOP 12'h206
`define SBC_IDX_OT_STOP 12'h207
`define SBC_IDX_FLT1_STOP 12'h208
`define SBC_IDX_BRK_DELAY 12'h209
`define SBC_IDX_STATUS 12'h2f0

// Reset values
`define SBC_RST_CTRL_MODE 16'h000b
`define SBC_RST_ABS_SYS 16'h0000
`define SBC_RST_ROT_DIR 16'h0000
`define SBC_RST_PULSE_PH 16'h0000
`define SBC_RST_ENOFF_STOP 16'h0003
`define SBC_RST_FLT2_STOP 16'h0002
`define SBC_RST_OT_STOP 16'h0008
`define SBC_RST_FLT1_STOP 16'h0002
`define SBC_RST_BRK_DELAY 16'h00fa

// Limits
`define SBC_MAX_CTRL_MODE 16'h000b
`define SBC_MAX_ABS_SYS 16'h0005
`define SBC_MAX_ROT_DIR 16'h0001
`define SBC_MAX_PULSE_PH 16'h0001
`define SBC_MIN_ENOFF_STOP (-16'sd5)
`define SBC_MAX_ENOFF_STOP 16'sd3
`define SBC_MIN_FLT2_STOP (-16'sd5)
`define SBC_MAX_FLT2_STOP 16'sd4
`define SBC_MAX_OT_STOP 16'h0008
`define SBC_MAX_FLT1_STOP 16'h0002
`define SBC_MAX_BRK_DELAY 16'h01f4

// Control mode codes
`define SBC_CM_NET 16'h000b
`define SBC_CM_FIRST_UNDEF 16'h0007

// Timing
`define SBC_CLK_HZ 10000000
`define SBC_MS_PER_S 1000

// Stop actions
`define SBC_ACT_NONE 4'h0
`define SBC_ACT_COAST 4'h1
`define SBC_ACT_RAMP1 4'h2
`define SBC_ACT_RAMP2 4'h3
`define SBC_ACT_ZERO 4'h4
`define SBC_ACT_ESTOP 4'h5
`define SBC_ACT_DYNBRK 4'h6
`define SBC_ACT_NET 4'h7
`define SBC_ACT_QUICK 4'h8

// States held after stop
`define SBC_END_RUN 2'h0
`define SBC_END_DEENERGIZE 2'h1
`define SBC_END_DYNBRK 2'h2
`define SBC_END_POSLOCK 2'h3

// Status bits
`define SBC_ST_CMD_READY 0
`define SBC_ST_STOPPING 1
`define SBC_ST_REJECT 7

`endif

/* File: core/sbc_params.v */
// Servo basic control parameter bank with AHB-Lite slave and stop decode
`timescale 1ns/1ps
`include "sbc_map.vh"

module sbc_params #(
  parameter MS_CYCLES = `SBC_CLK_HZ / `SBC_MS_PER_S
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Drive condition pins
  input wire servoEnable,
  input wire faultClass1,
  input wire faultClass2,
  input wire overtravel,
  input wire brakeOutputFunc,
  input wire powerUpReload,
  // Applied settings
  output reg [3:0] controlMode,
  output reg netCommMode,
  output reg [2:0] loopSelect,
  output reg [2:0] absoluteMode,
  output reg forwardIsCw,
  output reg pulsePhaseLag,
  // Stop and brake
  output reg [3:0] stopAction,
  output reg [1:0] stopEndState,
  output reg brakeOutput,
  output reg cmdReady
);

  localparam NPIN = 6;

  // Reset release
  reg rstMeta_q;
  reg rstSync_q;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  wire rstN = rstSync_q;

  // Pin synchronisers; change taken when stages two and three agree
  wire [NPIN-1:0] pinRaw = {powerUpReload, brakeOutputFunc, overtravel,
                            faultClass2, faultClass1, servoEnable};
  reg [NPIN-1:0] pinS1_q;
  reg [NPIN-1:0] pinS2_q;
  reg [NPIN-1:0] pinS3_q;
  reg [NPIN-1:0] pinF_q;
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : gPin
      always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
          pinS1_q[g] <= 1'b0;
          pinS2_q[g] <= 1'b0;
          pinS3_q[g] <= 1'b0;
          pinF_q[g] <= 1'b0;
        end else begin
          pinS1_q[g] <= pinRaw[g];
          pinS2_q[g] <= pinS1_q[g];
          pinS3_q[g] <= pinS2_q[g];
          // Costs a cycle, but a one-cycle glitch never counts
          if (pinS2_q[g] == pinS3_q[g]) begin
            pinF_q[g] <= pinS3_q[g];
          end
        end
      end
    end
  endgenerate
  wire enF = pinF_q[0];
  wire flt1F = pinF_q[1];
  wire flt2F = pinF_q[2];
  wire otF = pinF_q[3];
  wire brkFnF = pinF_q[4];
  wire reloadF = pinF_q[5];
  reg reloadD_q;

  // Stored words
  reg [15:0] ctrlMode_q;
  reg [15:0] absSys_q;
  reg [15:0] rotDir_q;
  reg [15:0] pulsePh_q;
  reg [15:0] enOffStop_q;
  reg [15:0] flt2Stop_q;
  reg [15:0] otStop_q;
  reg [15:0] flt1Stop_q;
  reg [15:0] brkDelay_q;
  reg reject_q;

  // Bus pipeline
  reg wrPend_q;
  reg rdPend_q;
  reg [11:0] idx_q;
  // Misaligned or high addresses map to an index nothing decodes
  wire addrOk = (haddr[1:0] == 2'b00) && (haddr[31:14] == 18'h0);
  wire take = hsel && htrans[1] && hready;
  wire [15:0] wd = hwdata[15:0];

  // Range check per word; stop check on the four setup words only
  reg wrOk;
  wire stopped = !enF;
  always @* begin
    wrOk = 1'b0;
    case (idx_q)
      `SBC_IDX_CTRL_MODE: wrOk = stopped && (wd <= `SBC_MAX_CTRL_MODE);
      `SBC_IDX_ABS_SYS: wrOk = stopped && (wd <= `SBC_MAX_ABS_SYS);
      `SBC_IDX_ROT_DIR: wrOk = stopped && (wd <= `SBC_MAX_ROT_DIR);
      `SBC_IDX_PULSE_PH: wrOk = stopped && (wd <= `SBC_MAX_PULSE_PH);
      `SBC_IDX_ENOFF_STOP: wrOk = ($signed(wd) >= `SBC_MIN_ENOFF_STOP) &&
                                  ($signed(wd) <= `SBC_MAX_ENOFF_STOP);
      `SBC_IDX_FLT2_STOP: wrOk = ($signed(wd) >= `SBC_MIN_FLT2_STOP) &&
                                 ($signed(wd) <= `SBC_MAX_FLT2_STOP);
      `SBC_IDX_OT_STOP: wrOk = (wd <= `SBC_MAX_OT_STOP);
      `SBC_IDX_FLT1_STOP: wrOk = (wd <= `SBC_MAX_FLT1_STOP);
      `SBC_IDX_BRK_DELAY: wrOk = (wd <= `SBC_MAX_BRK_DELAY);
      default: wrOk = 1'b0;
    endcase
  end
  wire isParam = (idx_q >= `SBC_IDX_CTRL_MODE) && (idx_q <= `SBC_IDX_BRK_DELAY) &&
                 (idx_q != 12'h204);
  wire wrNow = wrPend_q && isParam;

  // Status word
  wire [15:0] statusWord = {8'h00, reject_q, 1'b0, stopEndState, stopAction[1:0],
                            (stopAction != `SBC_ACT_NONE), cmdReady};

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      idx_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wrPend_q <= 1'b0;
      if (take) begin
        idx_q <= addrOk ? haddr[13:2] : 12'hfff;
        wrPend_q <= hwrite;
        rdPend_q <= !hwrite;
        // One wait state lets a read see a write just committed
        hreadyout <= hwrite;
      end else if (rdPend_q) begin
        rdPend_q <= 1'b0;
        hreadyout <= 1'b1;
        case (idx_q)
          `SBC_IDX_CTRL_MODE: hrdata <= {16'h0000, ctrlMode_q};
          `SBC_IDX_ABS_SYS: hrdata <= {16'h0000, absSys_q};
          `SBC_IDX_ROT_DIR: hrdata <= {16'h0000, rotDir_q};
          `SBC_IDX_PULSE_PH: hrdata <= {16'h0000, pulsePh_q};
          `SBC_IDX_ENOFF_STOP: hrdata <= {16'h0000, enOffStop_q};
          `SBC_IDX_FLT2_STOP: hrdata <= {16'h0000, flt2Stop_q};
          `SBC_IDX_OT_STOP: hrdata <= {16'h0000, otStop_q};
          `SBC_IDX_FLT1_STOP: hrdata <= {16'h0000, flt1Stop_q};
          `SBC_IDX_BRK_DELAY: hrdata <= {16'h0000, brkDelay_q};
          `SBC_IDX_STATUS: hrdata <= {16'h0000, statusWord};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      ctrlMode_q <= `SBC_RST_CTRL_MODE;
      absSys_q <= `SBC_RST_ABS_SYS;
      rotDir_q <= `SBC_RST_ROT_DIR;
      pulsePh_q <= `SBC_RST_PULSE_PH;
      enOffStop_q <= `SBC_RST_ENOFF_STOP;
      flt2Stop_q <= `SBC_RST_FLT2_STOP;
      otStop_q <= `SBC_RST_OT_STOP;
      flt1Stop_q <= `SBC_RST_FLT1_STOP;
      brkDelay_q <= `SBC_RST_BRK_DELAY;
      reject_q <= 1'b0;
    end else begin
      // refused write flagged, set wins over clear
      if (wrNow && !wrOk) begin
        reject_q <= 1'b1;
      end else if (wrPend_q && idx_q == `SBC_IDX_STATUS && wd[`SBC_ST_REJECT]) begin
        reject_q <= 1'b0;
      end
      if (wrNow && wrOk) begin
        case (idx_q)
          `SBC_IDX_CTRL_MODE: ctrlMode_q <= wd;
          `SBC_IDX_ABS_SYS: absSys_q <= wd;
          `SBC_IDX_ROT_DIR: rotDir_q <= wd;
          `SBC_IDX_PULSE_PH: pulsePh_q <= wd;
          `SBC_IDX_ENOFF_STOP: enOffStop_q <= wd;
          `SBC_IDX_FLT2_STOP: flt2Stop_q <= wd;
          `SBC_IDX_OT_STOP: otStop_q <= wd;
          `SBC_IDX_FLT1_STOP: flt1Stop_q <= wd;
          `SBC_IDX_BRK_DELAY: brkDelay_q <= wd;
          default: brkDelay_q <= brkDelay_q;
        endcase
      end
    end
  end

  // Applied settings; power-up-effective words load on reload edge only
  localparam [15:0] CM_RESET = `SBC_RST_CTRL_MODE;
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      reloadD_q <= 1'b0;
      controlMode <= CM_RESET[3:0];
      netCommMode <= 1'b1;
      loopSelect <= 3'b000;
      absoluteMode <= 3'h0;
      forwardIsCw <= 1'b0;
      pulsePhaseLag <= 1'b0;
    end else begin
      reloadD_q <= reloadF;
      controlMode <= ctrlMode_q[3:0];
      netCommMode <= (ctrlMode_q == `SBC_CM_NET);
      case (ctrlMode_q)
        16'h0000: loopSelect <= 3'b001;
        16'h0001: loopSelect <= 3'b010;
        16'h0002: loopSelect <= 3'b100;
        16'h0003: loopSelect <= 3'b101;
        16'h0004: loopSelect <= 3'b011;
        16'h0005: loopSelect <= 3'b110;
        16'h0006: loopSelect <= 3'b111;
        default: loopSelect <= 3'b000;
      endcase
      if (reloadF && !reloadD_q) begin
        absoluteMode <= absSys_q[2:0];
        forwardIsCw <= rotDir_q[0];
        pulsePhaseLag <= pulsePh_q[0];
      end
    end
  end

  // Stop decode; class-1 over class-2 over overtravel over enable-off
  // Fixed priority gives one action when several conditions overlap
  reg [3:0] actD;
  reg [1:0] endD;
  always @* begin
    actD = `SBC_ACT_NONE;
    endD = `SBC_END_RUN;
    if (flt1F) begin
      case (flt1Stop_q)
        16'h0000: begin actD = `SBC_ACT_COAST; endD = `SBC_END_DEENERGIZE; end
        16'h0001: begin actD = `SBC_ACT_DYNBRK; endD = `SBC_END_DEENERGIZE; end
        default: begin actD = `SBC_ACT_DYNBRK; endD = `SBC_END_DYNBRK; end
      endcase
    end else if (flt2F && brkFnF) begin
      actD = `SBC_ACT_QUICK;
      endD = `SBC_END_DYNBRK;
    end else if (flt2F) begin
      endD = flt2Stop_q[15] ? `SBC_END_DYNBRK : `SBC_END_DEENERGIZE;
      case (flt2Stop_q)
        16'h0000: actD = `SBC_ACT_COAST;
        16'h0001: actD = `SBC_ACT_RAMP1;
        16'h0002: actD = `SBC_ACT_RAMP2;
        16'h0003: actD = `SBC_ACT_ESTOP;
        16'h0004: actD = `SBC_ACT_DYNBRK;
        16'hffff: actD = `SBC_ACT_DYNBRK;
        16'hfffe: actD = `SBC_ACT_RAMP1;
        16'hfffd: actD = `SBC_ACT_RAMP2;
        16'hfffc: actD = `SBC_ACT_ESTOP;
        default: actD = `SBC_ACT_ZERO;
      endcase
    end else if (otF && otStop_q < 16'h0007) begin
      case (otStop_q)
        16'h0000: begin actD = `SBC_ACT_COAST; endD = `SBC_END_DEENERGIZE; end
        16'h0001: begin actD = `SBC_ACT_ZERO; endD = `SBC_END_POSLOCK; end
        16'h0002: begin actD = `SBC_ACT_ZERO; endD = `SBC_END_DEENERGIZE; end
        16'h0003: begin actD = `SBC_ACT_RAMP2; endD = `SBC_END_DEENERGIZE; end
        16'h0004: begin actD = `SBC_ACT_RAMP2; endD = `SBC_END_POSLOCK; end
        16'h0005: begin actD = `SBC_ACT_DYNBRK; endD = `SBC_END_DEENERGIZE; end
        default: begin actD = `SBC_ACT_DYNBRK; endD = `SBC_END_DYNBRK; end
      endcase
      // codes 7 and 8 fall through to the enable-off check
    end else if (!enF) begin
      endD = enOffStop_q[15] ? `SBC_END_DYNBRK : `SBC_END_DEENERGIZE;
      case (enOffStop_q)
        16'h0000: actD = `SBC_ACT_COAST;
        16'h0001: actD = `SBC_ACT_RAMP1;
        16'h0002: actD = `SBC_ACT_DYNBRK;
        16'h0003: actD = `SBC_ACT_NET;
        16'hffff: actD = `SBC_ACT_DYNBRK;
        16'hfffe: actD = `SBC_ACT_RAMP1;
        16'hfffd: actD = `SBC_ACT_ZERO;
        16'hfffc: actD = `SBC_ACT_RAMP2;
        default: actD = `SBC_ACT_NET;
      endcase
    end
  end

  // Millisecond tick; one count per ms keeps the delay counter small
  // Divider limits one ms to 2^24 clock cycles
  localparam integer MS_LAST_I = MS_CYCLES - 1;
  localparam [23:0] MS_LAST = MS_LAST_I[23:0];
  reg [23:0] msDiv_q;
  reg [15:0] msCnt_q;
  wire msTick = (msDiv_q == MS_LAST);

  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      stopAction <= `SBC_ACT_NONE;
      stopEndState <= `SBC_END_RUN;
      brakeOutput <= 1'b0;
      cmdReady <= 1'b0;
      msDiv_q <= 24'h000000;
      msCnt_q <= 16'h0000;
    end else begin
      stopAction <= actD;
      stopEndState <= endD;
      // brake on, then programmed wait before commands
      brakeOutput <= 1'b1;
      if (brakeOutput && !cmdReady) begin
        if (msCnt_q >= brkDelay_q) begin
          cmdReady <= 1'b1;
        end else if (msTick) begin
          msCnt_q <= msCnt_q + 16'h0001;
        end
        msDiv_q <= msTick ? 24'h000000 : msDiv_q + 24'h000001;
      end
    end
  end

endmodule // sbc_params

/* File: verif/sbc_params_props.sv */
// Port checker for the servo control parameter bank
`timescale 1ns/1ps
module sbc_params_chk (
  // Clock, reset and bus
  input logic sys_clk,
  input logic rst_b,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic hreadyout,
  // Drive pins
  input logic servoEnable,
  input logic faultClass1,
  input logic faultClass2,
  input logic overtravel,
  input logic brakeOutputFunc,
  // Decoded outputs
  input logic [3:0] controlMode,
  input logic netCommMode,
  input logic [2:0] loopSelect,
  input logic [3:0] stopAction,
  input logic [1:0] stopEndState,
  input logic brakeOutput,
  input logic cmdReady
);
  localparam logic [20:0] LOOPS = {3'h7, 3'h6, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1};
  logic take;
  logic [2:0] expLoop;
  assign take = hsel && htrans[1] && hready;
  assign expLoop = (controlMode < 4'h7) ? LOOPS[3 * controlMode +: 3] : 3'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Pins pass three sync flops, so eight stable cycles leave margin
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  net_mode_a: assert property (netCommMode == (controlMode == 4'hb))
    else $error("network mode flag wrong");
  loop_map_a: assert property (loopSelect == expLoop)
    else $error("loop select wrong");
  cmd_hold_a: assert property (cmdReady |=> cmdReady)
    else $error("command ready dropped");
  cmd_brake_a: assert property (cmdReady |-> brakeOutput)
    else $error("ready without brake output");
  run_idle_a: assert property ((servoEnable && !faultClass1 && !faultClass2 &&
    !overtravel)[*8] |=> stopAction == 4'h0 && stopEndState == 2'h0)
    else $error("stop while running");
  enoff_end_a: assert property ((!servoEnable && !faultClass1 && !faultClass2 &&
    !overtravel)[*8] |=> stopEndState inside {2'h1, 2'h2})
    else $error("enable off end state wrong");
  fault1_stop_a: assert property (faultClass1[*8] |=>
    stopAction inside {4'h1, 4'h6} && stopEndState inside {2'h1, 2'h2})
    else $error("class 1 stop wrong");
  quick_stop_a: assert property ((faultClass2 && brakeOutputFunc && !faultClass1)[*8]
    |=> stopAction == 4'h8 && stopEndState == 2'h2)
    else $error("quick stop not forced");
  cover property (take && !hwrite);
  cover property ($rose(cmdReady));
  cover property (stopAction == 4'h8);
  cover property (stopEndState == 2'h3);
endmodule // sbc_params_chk

bind sbc_params sbc_params_chk sbc_params_chk_i (.*);

/* File: verif/sbc_params_test.sv */
// Self-checking bench for the servo control parameter bank
`timescale 1ns/1ps
module sbc_params_test;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic servoEnable = 1'h0;
  logic faultClass1 = 1'h0;
  logic faultClass2 = 1'h0;
  logic overtravel = 1'h0;
  logic brakeOutputFunc = 1'h0;
  logic powerUpReload = 1'h0;
  wire hready, hresp, netCommMode, forwardIsCw, pulsePhaseLag, brakeOutput, cmdReady;
  wire [31:0] hrdata;
  wire [3:0] controlMode, stopAction;
  wire [2:0] loopSelect, absoluteMode;
  wire [1:0] stopEndState;
  logic [31:0] rd;
  int bad_count = 0;
  int compares = 0;
  logic [11:0] idxs [9] = '{12'h200, 12'h201, 12'h202, 12'h203, 12'h205, 12'h206,
    12'h207, 12'h208, 12'h209};
  logic [15:0] rsts [9] = '{16'h000b, 16'h0, 16'h0, 16'h0, 16'h0003, 16'h0002, 16'h0008,
    16'h0002, 16'h00fa};
  logic [15:0] maxs [9] = '{16'h000b, 16'h0005, 16'h0001, 16'h0001, 16'h0003, 16'h0004,
    16'h0008, 16'h0002, 16'h01f4};
  logic [15:0] bads [9] = '{16'h000c, 16'h0006, 16'h0002, 16'h0002, 16'hfffa, 16'hfffa,
    16'h0009, 16'h0003, 16'h01f5};
  logic [2:0] loopExp [7] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h3, 3'h6, 3'h7};

  // Short ms count keeps the brake delay wait small
  sbc_params #(.MS_CYCLES(10)) sbc_params_i (.*, .hreadyout(hready));

  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Samples hready as it stood at the edge
  task automatic waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'h1 && n < 20);
    if (hready !== 1'h1) begin
      bad_count++;
      summarize;
    end
  endtask

  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [15:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {18'h0, idx, 2'h0};
    waitRdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    waitRdy;
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [11:0] idx, input logic [15:0] exp);
    xfer(1'h0, idx, 16'h0);
    chk(rd, {16'h0, exp});
  endtask

  // Walks a stop word over its codes with the pins already set
  task automatic stopRun(input logic [11:0] idx, input int lo, input int hi,
    input logic [59:0] tab);
    for (int v = lo; v <= hi; v++) begin
      xfer(1'h1, idx, 16'(v));
      repeat (6) @(posedge sys_clk);
      chk(32'({stopAction, stopEndState}), 32'(tab[6 * (v - lo) +: 6]));
    end
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge sys_clk);
    repeat (2490) @(posedge sys_clk);
    chk(32'(cmdReady), 32'h0);
    chk(32'(brakeOutput), 32'h1);
    repeat (20) @(posedge sys_clk);
    chk(32'(cmdReady), 32'h1);
    for (int i = 0; i < 9; i++) begin
      rdchk(idxs[i], rsts[i]);
      xfer(1'h1, idxs[i], maxs[i]);
      rdchk(idxs[i], maxs[i]);
      xfer(1'h1, idxs[i], bads[i]);
      chk(32'(hresp), 32'h0);
      rdchk(idxs[i], maxs[i]);
    end
    xfer(1'h0, 12'h2f0, 16'h0);
    chk(32'(rd[7]), 32'h1);
    xfer(1'h1, 12'h2f0, 16'h0080);
    xfer(1'h0, 12'h2f0, 16'h0);
    chk(32'(rd[7]), 32'h0);
    // Unmapped index reads zero
    xfer(1'h1, 12'h204, 16'h0005);
    rdchk(12'h204, 16'h0);
    // Codes 7 to 10 are undefined and enable no loop
    for (int m = 0; m < 12; m++) begin
      xfer(1'h1, 12'h200, 16'(m));
      repeat (2) @(posedge sys_clk);
      chk(32'({controlMode, loopSelect, netCommMode}),
        32'({4'(m), (m < 7) ? loopExp[m] : 3'h0, m == 11}));
    end
    xfer(1'h1, 12'h201, 16'h0003);
    chk(32'({absoluteMode, forwardIsCw, pulsePhaseLag}), 32'h0);
    powerUpReload <= 1'h1;
    repeat (6) @(posedge sys_clk);
    powerUpReload <= 1'h0;
    repeat (6) @(posedge sys_clk);
    chk(32'({absoluteMode, forwardIsCw, pulsePhaseLag}), 32'h0f);
    stopRun(12'h205, -5, 3, {6'h1d, 6'h19, 6'h09, 6'h05, 6'h1a, 6'h0a, 6'h12, 6'h0e,
      6'h1e});
    servoEnable <= 1'h1;
    faultClass2 <= 1'h1;
    stopRun(12'h206, -5, 4, {6'h19, 6'h15, 6'h0d, 6'h09, 6'h05, 6'h1a, 6'h0a, 6'h0e,
      6'h16, 6'h12});
    brakeOutputFunc <= 1'h1;
    stopRun(12'h206, 0, 0, 60'h22);
    brakeOutputFunc <= 1'h0;
    faultClass2 <= 1'h0;
    overtravel <= 1'h1;
    // Codes 1 and 4 end in position lock, the choice for a vertical axis
    stopRun(12'h207, 0, 8, {6'h00, 6'h00, 6'h1a, 6'h19, 6'h0f, 6'h0d, 6'h11, 6'h13,
      6'h05});
    overtravel <= 1'h0;
    faultClass1 <= 1'h1;
    stopRun(12'h208, 0, 2, {6'h1a, 6'h19, 6'h05});
    faultClass1 <= 1'h0;
    // Setup words locked while enabled
    xfer(1'h1, 12'h200, 16'h0000);
    rdchk(12'h200, 16'h000b);
    xfer(1'h1, 12'h202, 16'h0000);
    rdchk(12'h202, 16'h0001);
    xfer(1'h1, 12'h203, 16'h0000);
    rdchk(12'h203, 16'h0001);
    summarize;
  end
endmodule // sbc_params_test
